// ==== pmx_pkg.sv ====
package pmx_pkg;
  // ************************************************************
  // Register map (byte addresses on the AHB-Lite slave)
  // ************************************************************
  localparam logic [7:0] ADDR_PIN_ASSIGN = 8'h00;
  localparam logic [7:0] ADDR_WIN_SIZE = 8'h04;
  localparam logic [7:0] ADDR_WIN_BASE = 8'h08;
  localparam logic [7:0] ADDR_BANK_ONE = 8'h0C;
  localparam logic [7:0] ADDR_BANK_TWO = 8'h10;
  localparam logic [7:0] ADDR_ONCHIP = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;

  // ************************************************************
  // Field layouts and writable masks
  // ************************************************************
  localparam logic [7:0] PIN_ASSIGN_MASK = 8'h3F;
  localparam logic [7:0] WIN_SIZE_MASK = 8'hF3;
  localparam logic [7:0] WIN_BASE_MASK = 8'hEE;
  localparam logic [7:0] BANK_MASK = 8'h7E;
  localparam int FIRST_WINDOW_SIZE_LSB = 0;
  localparam int SECOND_WINDOW_SIZE_LSB = 4;
  localparam int GPSEL1_BIT = 6;
  localparam int GPSEL2_BIT = 7;
  localparam int W1BASE_LSB = 1;
  localparam int W2BASE_LSB = 5;
  localparam int BANK_LSB = 1;
  localparam logic [7:0] REG_RESET = 8'h00;

  // ************************************************************
  // Window sizes
  // ************************************************************
  typedef enum logic [1:0] {
    PMX_WIN_OFF = 2'b00,
    PMX_WIN_8K = 2'b01,
    PMX_WIN_16K = 2'b10,
    PMX_WIN_32K = 2'b11
  } pmx_wsize_t;
  localparam logic [2:0] BASE_4000 = 3'b010;
endpackage : pmx_pkg

// ==== pmx_window.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// One window: hit decode and expanded-address build
// ************************************************************
module pmx_window (
  input wire logic [15:0] cpu_addr,
  input wire logic [1:0] wsize,
  input wire logic [2:0] wbase,
  input wire logic [5:0] bank,
  output logic hit,
  output logic [5:0] xline,
  output logic [2:0] used_low
);
  // Base truncated to size, then upper-bit compare
  // Bank bits go out on their own lines, so a bigger window drops the low bank bits
  // used_low marks lines 15..13 that do not carry the plain CPU bit
  always_comb begin
    hit = 1'b0;
    xline = 6'h00;
    used_low = 3'b000;
    case (pmx_pkg::pmx_wsize_t'(wsize))
      pmx_pkg::PMX_WIN_8K: begin
        hit = (cpu_addr[15:13] == wbase);
        xline = bank;
        used_low = 3'b111;
      end
      pmx_pkg::PMX_WIN_16K: begin
        hit = (cpu_addr[15:14] == wbase[2:1]);
        xline = {bank[5:1], cpu_addr[13]};
        used_low = 3'b110;
      end
      pmx_pkg::PMX_WIN_32K: begin
        if (wbase[2:1] == 2'b01) begin
          // Based at 0x4000: spans 0x4000..0xBFFF, bit 14 inverted
          hit = (cpu_addr[15:14] == 2'b01) || (cpu_addr[15:14] == 2'b10);
          xline = {bank[5:2], ~cpu_addr[14], cpu_addr[13]};
          used_low = 3'b110;
        end else begin
          hit = (cpu_addr[15] == wbase[2]);
          xline = {bank[5:2], cpu_addr[14:13]};
          used_low = 3'b100;
        end
      end
      default: begin
        hit = 1'b0;
      end
    endcase
  end
endmodule : pmx_window
`default_nettype wire

// ==== pmx_paged_mem.sv ====
// The AHB-Lite slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module pmx_paged_mem (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [15:0] cpu_addr,
  input wire logic onchip_hit,
  input wire logic rom_hit,
  output logic [5:0] port_out,
  output logic [5:0] port_is_addr,
  output logic [19:0] exp_addr,
  output logic gp1_use_exp,
  output logic gp2_use_exp,
  output logic ext_select,
  output logic rom_select,
  output logic onchip_select,
  output logic in_window
);
  // ************************************************************
  // Registers
  // ************************************************************
  logic [7:0] pin_assign_r, pin_assign_nxt;
  logic [7:0] size_r, size_nxt;
  logic [7:0] base_r, base_nxt;
  logic [7:0] bank1_r, bank1_nxt;
  logic [7:0] bank2_r, bank2_nxt;
  logic wr_pend_r, wr_pend_nxt;
  logic [7:0] wr_addr_r, wr_addr_nxt;
  logic [31:0] hrdata_r, hrdata_nxt;
  logic [7:0] rd_val;
  logic [15:0] cpu_sync1_r, cpu_sync2_r;
  logic [1:0] onchip_sync1_r, onchip_sync2_r;
  logic phase_ok;

  assign phase_ok = hsel && hready && htrans[1];

  // Read mux; unimplemented bits forced low by masks
  always_comb begin
    rd_val = 8'h00;
    if (haddr == pmx_pkg::ADDR_PIN_ASSIGN) begin
      rd_val = pin_assign_r & pmx_pkg::PIN_ASSIGN_MASK;
    end else if (haddr == pmx_pkg::ADDR_WIN_SIZE) begin
      rd_val = size_r & pmx_pkg::WIN_SIZE_MASK;
    end else if (haddr == pmx_pkg::ADDR_WIN_BASE) begin
      rd_val = base_r & pmx_pkg::WIN_BASE_MASK;
    end else if (haddr == pmx_pkg::ADDR_BANK_ONE) begin
      rd_val = bank1_r & pmx_pkg::BANK_MASK;
    end else if (haddr == pmx_pkg::ADDR_BANK_TWO) begin
      rd_val = bank2_r & pmx_pkg::BANK_MASK;
    end else if (haddr == pmx_pkg::ADDR_STATUS) begin
      rd_val = {ext_select, rom_select, onchip_select, in_window, 4'h0};
    end else begin
      rd_val = 8'h00; // Unmapped reads zero, still OKAY
    end
  end

  // Bus slave: zero wait states, write lands in data phase
  always_comb begin
    wr_pend_nxt = phase_ok && hwrite;
    wr_addr_nxt = phase_ok ? haddr : wr_addr_r;
    hrdata_nxt = (phase_ok && !hwrite) ? {24'h00_0000, rd_val} : hrdata_r;
    pin_assign_nxt = pin_assign_r;
    size_nxt = size_r;
    base_nxt = base_r;
    bank1_nxt = bank1_r;
    bank2_nxt = bank2_r;
    if (wr_pend_r) begin
      if (wr_addr_r == pmx_pkg::ADDR_PIN_ASSIGN) begin
        pin_assign_nxt = hwdata[7:0] & pmx_pkg::PIN_ASSIGN_MASK;
      end else if (wr_addr_r == pmx_pkg::ADDR_WIN_SIZE) begin
        size_nxt = hwdata[7:0] & pmx_pkg::WIN_SIZE_MASK;
      end else if (wr_addr_r == pmx_pkg::ADDR_WIN_BASE) begin
        base_nxt = hwdata[7:0] & pmx_pkg::WIN_BASE_MASK;
      end else if (wr_addr_r == pmx_pkg::ADDR_BANK_ONE) begin
        bank1_nxt = hwdata[7:0] & pmx_pkg::BANK_MASK;
      end else if (wr_addr_r == pmx_pkg::ADDR_BANK_TWO) begin
        bank2_nxt = hwdata[7:0] & pmx_pkg::BANK_MASK;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_assign_r <= pmx_pkg::REG_RESET;
      size_r <= pmx_pkg::REG_RESET;
      base_r <= pmx_pkg::REG_RESET;
      bank1_r <= pmx_pkg::REG_RESET;
      bank2_r <= pmx_pkg::REG_RESET;
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata_r <= 32'h0000_0000;
    end else begin
      pin_assign_r <= pin_assign_nxt;
      size_r <= size_nxt;
      base_r <= base_nxt;
      bank1_r <= bank1_nxt;
      bank2_r <= bank2_nxt;
      wr_pend_r <= wr_pend_nxt;
      wr_addr_r <= wr_addr_nxt;
      hrdata_r <= hrdata_nxt;
    end
  end

  assign hrdata = hrdata_r;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // ************************************************************
  // CPU side inputs: treated as foreign, two-flop synchronised
  // ************************************************************
  // Costs two cycles of latency but keeps the decode metastability-safe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_sync1_r <= 16'h0000;
      cpu_sync2_r <= 16'h0000;
      onchip_sync1_r <= 2'b00;
      onchip_sync2_r <= 2'b00;
    end else begin
      cpu_sync1_r <= cpu_addr;
      cpu_sync2_r <= cpu_sync1_r;
      onchip_sync1_r <= {rom_hit, onchip_hit};
      onchip_sync2_r <= onchip_sync1_r;
    end
  end

  // ************************************************************
  // Window decode
  // ************************************************************
  logic hit1, hit2;
  logic [5:0] x1, x2;
  logic [2:0] use1, use2;

  pmx_window u_win1 (
    .cpu_addr(cpu_sync2_r),
    .wsize(size_r[pmx_pkg::FIRST_WINDOW_SIZE_LSB +: 2]),
    .wbase(base_r[pmx_pkg::W1BASE_LSB +: 3]),
    .bank(bank1_r[pmx_pkg::BANK_LSB +: 6]),
    .hit(hit1),
    .xline(x1),
    .used_low(use1)
  );

  pmx_window u_win2 (
    .cpu_addr(cpu_sync2_r),
    .wsize(size_r[pmx_pkg::SECOND_WINDOW_SIZE_LSB +: 2]),
    .wbase(base_r[pmx_pkg::W2BASE_LSB +: 3]),
    .bank(bank2_r[pmx_pkg::BANK_LSB +: 6]),
    .hit(hit2),
    .xline(x2),
    .used_low(use2)
  );

  // Output values; the windows pick which low lines carry bank bits
  logic [5:0] xsel, pout_nxt, pout_r, pdir_r;
  logic [19:0] exp_nxt, exp_r;
  logic win_nxt, win_r, ext_nxt, ext_r, rom_nxt, rom_r, onc_nxt, onc_r;
  logic [2:0] used_any;

  always_comb begin
    xsel = 6'h00;
    win_nxt = hit1 || hit2;
    used_any = 3'b000;
    if (hit1) begin
      xsel = x1;
      used_any = use1;
    end else if (hit2) begin
      xsel = x2;
      used_any = use2;
    end
    // low lines without window need carry CPU bits
    pout_nxt = {xsel[5:3], cpu_sync2_r[15:13]};
    if (win_nxt) begin
      pout_nxt = xsel;
    end else begin
      pout_nxt = {3'b000, cpu_sync2_r[15:13]};
    end
    exp_nxt = win_nxt ? {1'b0, xsel, cpu_sync2_r[12:0]} : {4'h0, cpu_sync2_r};
    onc_nxt = onchip_sync2_r[0];
    rom_nxt = !onchip_sync2_r[0] && onchip_sync2_r[1]
              && (!win_nxt || xsel[5:3] == 3'b000);
    ext_nxt = !onc_nxt && !rom_nxt;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pout_r <= 6'h00;
      pdir_r <= 6'h00;
      exp_r <= 20'h0_0000;
      win_r <= 1'b0;
      ext_r <= 1'b0;
      rom_r <= 1'b0;
      onc_r <= 1'b0;
    end else begin
      pout_r <= pout_nxt & pin_assign_r[5:0];
      pdir_r <= pin_assign_r[5:0];
      exp_r <= exp_nxt;
      win_r <= win_nxt;
      ext_r <= ext_nxt;
      rom_r <= rom_nxt;
      onc_r <= onc_nxt;
    end
  end

  assign port_out = pout_r;
  assign port_is_addr = pdir_r;
  assign exp_addr = exp_r;
  assign in_window = win_r;
  assign ext_select = ext_r;
  assign rom_select = rom_r;
  assign onchip_select = onc_r;
  assign gp1_use_exp = size_r[pmx_pkg::GPSEL1_BIT];
  assign gp2_use_exp = size_r[pmx_pkg::GPSEL2_BIT];

  // ************************************************************
  // Assertions
  // ************************************************************
  a_ro_bits_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (pin_assign_r[7:6] == 2'b00) && (size_r[3:2] == 2'b00))
    else $error("unimplemented bits set");
  a_win_one_wins: assert property (@(posedge hclk) disable iff (!hresetn)
    (hit1 && hit2) |=> (exp_r[18:13] == $past(x1)))
    else $error("window two won overlap");
  a_onchip_first: assert property (@(posedge hclk) disable iff (!hresetn)
    onchip_sync2_r[0] |=> (onc_r && !ext_r && !rom_r))
    else $error("onchip lost priority");
  a_rom_bank_zero: assert property (@(posedge hclk) disable iff (!hresetn)
    (hit1 && x1[5:3] != 3'b000 && !onchip_sync2_r[0]) |=> !rom_r)
    else $error("rom in nonzero bank");
  a_pass_outside: assert property (@(posedge hclk) disable iff (!hresetn)
    (!hit1 && !hit2) |=> (exp_r == {4'h0, $past(cpu_sync2_r)}))
    else $error("address altered outside window");
  a_pin_gating: assert property (@(posedge hclk) disable iff (!hresetn)
    ((pout_r & ~pdir_r) == 6'h00))
    else $error("io pin carries address");
  a_win_32k_inv: assert property (@(posedge hclk) disable iff (!hresetn)
    (hit1 && size_r[1:0] == 2'b11 && base_r[3:2] == 2'b01)
    |=> (exp_r[14] == !$past(cpu_sync2_r[14])))
    else $error("bit 14 not inverted");
  a_low_lines_cpu: assert property (@(posedge hclk) disable iff (!hresetn)
    win_nxt |=> (((exp_r[15:13] ^ $past(cpu_sync2_r[15:13])) & ~$past(used_any)) == 3'b000))
    else $error("low line lost cpu bit");
  a_zero_wait: assert property (@(posedge hclk) disable iff (!hresetn)
    phase_ok |-> ##1 (hreadyout && !hresp))
    else $error("slave stalled");
  c_win1_hit: cover property (@(posedge hclk) disable iff (!hresetn) hit1);
  c_overlap: cover property (@(posedge hclk) disable iff (!hresetn) hit1 && hit2);
  c_rom_bank: cover property (@(posedge hclk) disable iff (!hresetn) rom_r && win_r);
endmodule : pmx_paged_mem
`default_nettype wire

// ==== pmx_onchip_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ************************************************************
// On-chip decode seen beside the paging block
// ************************************************************
module pmx_onchip_model #(
  parameter bit ROM_ON = 1'b1
) (
  input wire logic [15:0] cpu_addr,
  output logic onchip_hit,
  output logic rom_hit
);
  // Fixed map: registers and RAM low, ROM high, so overlaps are easy to aim
  assign onchip_hit = cpu_addr < 16'h0380;
  assign rom_hit = ROM_ON && cpu_addr >= 16'hA000; // Only while ROM is enabled
endmodule : pmx_onchip_model
`default_nettype wire

// ==== paged_memory_expansion_tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module paged_memory_expansion_tb;
  typedef struct packed {
    logic [5:0] pin;
    logic [7:0] sz;
    logic [7:0] bs;
    logic [5:0] b1;
    logic [5:0] b2;
    logic [15:0] a;
    logic [19:0] x;
  } pmx_row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'b010;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [15:0] cpu_addr = 16'h0000;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, onchip_hit, rom_hit, gp1, gp2, ext, rom, onc, inw, w;
  logic [5:0] port_out, port_is_addr;
  logic [19:0] exp_addr;
  int miscompares = 0;
  int compares = 0;
  logic [7:0] msk [6] = '{8'h3F, 8'hF3, 8'hEE, 8'h7E, 8'h7E, 8'h00};
  // Bases sit on multiples of the window size, as software must place them, except the 32K window based at 0x4000
  pmx_row_t rows [13] = '{
    '{6'h3F, 8'h01, 8'h02, 6'h2A, 6'h00, 16'h3456, 20'h5_5456},
    '{6'h3F, 8'h01, 8'h02, 6'h2A, 6'h00, 16'h5456, 20'h0_5456},
    '{6'h3F, 8'h42, 8'h08, 6'h15, 6'h00, 16'h9ABC, 20'h2_9ABC},
    '{6'h3F, 8'h83, 8'h04, 6'h3C, 6'h00, 16'h4123, 20'h7_8123},
    '{6'h3F, 8'h83, 8'h04, 6'h3C, 6'h00, 16'hB123, 20'h7_F123},
    '{6'h3F, 8'hC3, 8'h08, 6'h3C, 6'h00, 16'hC000, 20'h7_C000},
    '{6'h3F, 8'h31, 8'h88, 6'h01, 6'h3C, 16'h8010, 20'h0_2010},
    '{6'h3F, 8'h31, 8'h88, 6'h01, 6'h3C, 16'hA010, 20'h7_A010},
    '{6'h05, 8'h00, 8'h00, 6'h00, 6'h00, 16'hE000, 20'h0_E000},
    '{6'h3F, 8'h01, 8'h0A, 6'h07, 6'h00, 16'hA100, 20'h0_E100},
    '{6'h3F, 8'h01, 8'h0A, 6'h08, 6'h00, 16'hA100, 20'h1_0100},
    '{6'h3F, 8'h01, 8'h00, 6'h3F, 6'h00, 16'h0100, 20'h7_E100},
    '{6'h3F, 8'h01, 8'h0E, 6'h00, 6'h00, 16'hE000, 20'h0_0000}};

  // Free-running bus clock, 5 ns period
  always #2.5 hclk = ~hclk;

  pmx_paged_mem i_pmx_paged_mem (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .cpu_addr(cpu_addr),
    .onchip_hit(onchip_hit), .rom_hit(rom_hit), .port_out(port_out),
    .port_is_addr(port_is_addr), .exp_addr(exp_addr), .gp1_use_exp(gp1), .gp2_use_exp(gp2),
    .ext_select(ext), .rom_select(rom), .onchip_select(onc), .in_window(inw));
  pmx_onchip_model i_pmx_onchip_model (.cpu_addr(cpu_addr), .onchip_hit(onchip_hit),
    .rom_hit(rom_hit));

  // ************************************************************
  // Reporting and bus tasks
  // ************************************************************
  task results;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e) begin
      $display("[ERR] %s expected %h seen %h", n, e, g);
      miscompares++;
    end
  endtask : chk

  // Bounded wait on the ready sampled at this edge
  task wait_rdy;
    int n;
    n = 0;
    while (hreadyout !== 1'b1) begin
      @(posedge hclk);
      n++;
      if (n > 20) begin
        miscompares++;
        results();
      end
    end
  endtask : wait_rdy

  // One word transfer; entered just after a rising edge
  task bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'b10;
    @(posedge hclk);
    wait_rdy();
    htrans <= 2'b00;
    hwdata <= {24'h00_0000, d};
    @(posedge hclk);
    wait_rdy();
    rd = hrdata;
  endtask : bus

  // Window hit from size code and base field, base truncated to size
  function automatic logic hit(input logic [1:0] s, input logic [2:0] b, input logic [15:0] a);
    case (s)
      2'b01: return a[15:13] == b;
      2'b10: return a[15:14] == b[2:1];
      2'b11: return b[2] ? a[15] : (b[1] ? (a >= 16'h4000 && a < 16'hC000) : !a[15]);
      default: return 1'b0;
    endcase
  endfunction : hit

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    repeat (12) @(posedge hclk);
    chk("reset_outputs", 32'h0000_0001, 32'({exp_addr, port_out, inw, hresp, hreadyout}));
    hresetn <= 1'b1;
    @(posedge hclk);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, 8'(i * 4), 8'h00);
      // Status shows the on-chip select, since CPU address zero is on-chip space
      chk("reg_reset", (i == 6) ? 32'h0000_0020 : 32'h0000_0000, rd);
    end
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      bus(1'b1, 8'(i * 4), 8'hFF);
      bus(1'b0, 8'(i * 4), 8'h00);
      chk("reg_mask", 32'(msk[i]), rd);
    end
    $display("test register masks done");
    foreach (rows[k]) begin
      bus(1'b1, 8'h00, {2'b00, rows[k].pin});
      bus(1'b1, 8'h04, rows[k].sz);
      bus(1'b1, 8'h08, rows[k].bs);
      bus(1'b1, 8'h0C, {1'b0, rows[k].b1, 1'b0});
      bus(1'b1, 8'h10, {1'b0, rows[k].b2, 1'b0});
      cpu_addr <= rows[k].a;
      repeat (6) @(posedge hclk);
      w = hit(rows[k].sz[1:0], rows[k].bs[3:1], rows[k].a)
        | hit(rows[k].sz[5:4], rows[k].bs[7:5], rows[k].a);
      rd[0] = rom_hit & !onchip_hit & (!w | rows[k].x[18:16] == 3'b000);
      chk("exp_addr", 32'(rows[k].x), 32'(exp_addr));
      chk("port_out", 32'((w ? rows[k].x[18:13] : {3'b000, rows[k].a[15:13]}) & rows[k].pin),
        32'(port_out));
      chk("selects", 32'({rows[k].sz[7:6], rd[0], onchip_hit, w, !onchip_hit & !rd[0]}),
        32'({gp2, gp1, rom, onc, inw, ext}));
      chk("pin_field", 32'(rows[k].pin), 32'(port_is_addr));
    end
    $display("test window rows done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    chk("mid_reset", 32'h0000_0000, 32'({exp_addr, port_out, port_is_addr}));
    hresetn <= 1'b1;
    @(posedge hclk);
    bus(1'b0, 8'h04, 8'h00);
    chk("size_after_reset", 32'h0000_0000, rd);
    $display("test second reset done");
    results();
  end

  // Overall guard against a hung run
  initial begin
    #400000;
    miscompares++;
    results();
  end
endmodule : paged_memory_expansion_tb
`default_nettype wire
